// *** include/cpu_regfile_defs.svh ***
// constants for the working register file and flag word
`ifndef CPU_REGFILE_DEFS_SVH
`define CPU_REGFILE_DEFS_SVH
`define RF_NUM_REGS      32
`define RF_X_LO_IDX      5'h1a
`define RF_Y_LO_IDX      5'h1c
`define RF_Z_LO_IDX      5'h1e
`define DS_IO_BASE       16'h0020
`define DS_IO_LAST       16'h005f
`define IO_FLAGS_ADDR    6'h3f
`define IO_SP_LO_ADDR    6'h3d
`define IO_SP_HI_ADDR    6'h3e
`define FLG_GATE         7
`define FLG_COPY         6
`define FLG_NIBBLE       5
`define FLG_POLARITY     4
`define FLG_SWRAP        3
`define FLG_MSB          2
`define FLG_ZERO         1
`define FLG_UWRAP        0
`define FLAGS_RESET      8'h00
`define SP_RESET         16'h0000
`endif

// *** include/cpu_regfile_pkg.sv ***
// types shared by the register file and flag logic
package cpu_regfile_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [4:0] ridx_t;
  // flag update bundle from the alu
  typedef struct packed {
    logic [7:0] mask;   // which flags this op touches
    logic [7:0] value;  // new flag values
  } flag_upd_s;
  // operand/result port width schemes
  typedef enum logic [3:0] {
    SCH_ONE8  = 4'h1,
    SCH_TWO8  = 4'h2,
    SCH_TWO16 = 4'h4,
    SCH_ONE16 = 4'h8
  } scheme_e;
  // flag word control state
  typedef enum logic [2:0] {
    IRQ_IDLE   = 3'h1,
    IRQ_TAKEN  = 3'h2,
    IRQ_RETURN = 3'h4
  } irq_state_e;
endpackage

// *** verilog/regfile_mem.sv ***
// thirty-two by eight working register memory, registered read ports
`timescale 1ns/1ps
module regfile_mem
  import cpu_regfile_pkg::*;
#(
  parameter int NREGS = 32
) (
  input  wire logic        clk,        // cpu clock
  input  wire logic        rst,        // synchronous reset
  input  wire logic        we_lo,      // write low byte
  input  wire logic        we_hi,      // write high byte at idx+1
  input  wire ridx_t       wr_idx,     // write index
  input  wire byte_t       wr_lo,      // low write data
  input  wire byte_t       wr_hi,      // high write data
  input  wire ridx_t       rd_idx_a,   // read port a index
  input  wire ridx_t       rd_idx_b,   // read port b index
  input  wire ridx_t       rd_idx_c,   // read port c index
  output logic       [7:0] rd_a,       // port a data
  output logic       [7:0] rd_b,       // port b data
  output logic       [7:0] rd_c        // port c data
);
  byte_t mem_q [NREGS];  // storage cells
  ridx_t wr_hi_idx;      // high byte index

  assign wr_hi_idx = wr_idx + 5'h01;

  // write with pair support
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NREGS; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else begin
      if (we_lo) begin
        mem_q[wr_idx] <= wr_lo;
      end
      if (we_hi) begin
        mem_q[wr_hi_idx] <= wr_hi;
      end
    end
  end

  // registered reads; new data forwarded
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_a <= 8'h00;
      rd_b <= 8'h00;
      rd_c <= 8'h00;
    end else begin
      rd_a <= (we_lo && wr_idx == rd_idx_a) ? wr_lo :
              (we_hi && wr_hi_idx == rd_idx_a) ? wr_hi : mem_q[rd_idx_a];
      rd_b <= (we_lo && wr_idx == rd_idx_b) ? wr_lo :
              (we_hi && wr_hi_idx == rd_idx_b) ? wr_hi : mem_q[rd_idx_b];
      rd_c <= (we_lo && wr_idx == rd_idx_c) ? wr_lo :
              (we_hi && wr_hi_idx == rd_idx_c) ? wr_hi : mem_q[rd_idx_c];
    end
  end
endmodule

// *** verilog/cpu_regfile.sv ***
// working register file, pointer pairs, data space port and flag word
`timescale 1ns/1ps
`include "cpu_regfile_defs.svh"
module cpu_regfile
  import cpu_regfile_pkg::*;
(
  input  wire logic         CLK,          // cpu clock
  input  wire logic         SYS_RST,      // synchronous reset, high
  input  wire logic [4:0]   RD_IDX_A,     // operand a register
  input  wire logic [4:0]   RD_IDX_B,     // operand b register
  input  wire scheme_e      SCHEME,       // port width scheme
  input  wire logic         RES_WE,       // write result
  input  wire logic [4:0]   RES_IDX,      // result register
  input  wire logic [15:0]  RES_DATA,     // result, high half for 16-bit
  input  wire logic         FLAG_WE,      // alu flag update strobe
  input  wire flag_upd_s    FLAG_UPD,     // flags from alu
  input  wire logic         COPY_FROM,    // copy_from_reg_bit
  input  wire logic         COPY_TO,      // copy_to_reg_bit
  input  wire logic [2:0]   COPY_BIT,     // selected bit
  input  wire logic [4:0]   COPY_IDX,     // selected register
  input  wire logic         GATE_ON,      // gate_on_op
  input  wire logic         GATE_OFF,     // gate_off_op
  input  wire logic         IRQ_TAKE,     // interrupt entry
  input  wire logic         IRQ_RET,      // interrupt_return_op
  input  wire logic [7:0]   IRQ_PEND,     // pending lines, bit 0 first
  input  wire logic         DS_RE,        // data space read
  input  wire logic         DS_WE,        // data space write
  input  wire logic [15:0]  DS_ADDR,      // data space address
  input  wire logic [7:0]   DS_WDATA,     // data space write data
  input  wire logic         IO_RE,        // direct io read
  input  wire logic         IO_WE,        // direct io write
  input  wire logic [5:0]   IO_ADDR,      // direct io address
  input  wire logic [7:0]   IO_WDATA,     // direct io write data
  input  wire logic         SP_PUSH2,     // call/irq return push
  input  wire logic         SP_POP2,      // ret pop
  input  wire logic [15:0]  PM_WORD,      // fetched program word
  input  wire logic         PM_VALID,     // fetch word valid
  output logic      [15:0]  OPND_A,       // operand a, 16 bits only for SCH_ONE16, high byte zero otherwise
  output logic      [7:0]   OPND_B,       // operand b
  output logic      [7:0]   FLAGS,        // alu_flags_word
  output logic      [15:0]  PTR_X,        // pointer pair 26/27
  output logic      [15:0]  PTR_Y,        // pointer pair 28/29
  output logic      [15:0]  PTR_Z,        // pointer pair 30/31, table ptr
  output logic      [7:0]   DS_RDATA,     // data space read data
  output logic              DS_IO_HIT,    // last read was io window
  output logic      [5:0]   IO_SEL,       // io address of last access
  output logic      [7:0]   IO_RDATA,     // direct io read data
  output logic              IRQ_GRANT,    // an interrupt may be taken
  output logic      [2:0]   IRQ_VEC,      // winning vector number
  output logic      [15:0]  SP_OUT,       // stack_top_pointer
  output logic      [15:0]  INSN_Q,       // prefetched instruction
  output logic              INSN_LONG     // prefetch needs a second word
);
  byte_t        flags_q;         // flag word
  byte_t        flags_d;         // next flag word
  logic [15:0]  sp_q;            // stack_top_pointer
  logic [15:0]  insn_q;          // prefetch register
  logic         long_q;          // two-word marker
  irq_state_e   irq_q;           // gate state tracker
  logic         mem_we_lo;       // memory low write
  logic         mem_we_hi;       // memory high write
  ridx_t        mem_widx;        // memory write index
  byte_t        mem_wlo;         // memory low data
  byte_t        mem_whi;         // memory high data
  byte_t        rd_a;            // port a
  byte_t        rd_b;            // port b
  byte_t        rd_c;            // port c
  ridx_t        idx_c;           // third port index
  logic         ds_reg_hit;      // data access hits registers
  logic         ds_io_hit;       // data access hits io window
  logic         io_wr;           // any io write
  logic [5:0]   io_wa;           // io write address
  byte_t        io_wd;           // io write data
  logic         io_rd;           // any io read
  logic [5:0]   io_ra;           // io read address
  byte_t        copy_src_q;      // register for bit copy
  ridx_t        hi_idx_a;        // high half of operand a
  logic [15:0]  x_q;             // pointer mirrors
  logic [15:0]  y_q;
  logic [15:0]  z_q;

  // true when address falls in the register window
  function automatic logic in_regs(input logic [15:0] a);
    return a < 16'h0020;
  endfunction

  // true when address falls in the io window
  function automatic logic in_io(input logic [15:0] a);
    return (a >= `DS_IO_BASE) && (a <= `DS_IO_LAST);
  endfunction

  // io read mux for the owned io registers
  function automatic byte_t io_mux(input logic [5:0] a, input byte_t f,
                                   input logic [15:0] s);
    case (a)
      `IO_FLAGS_ADDR: return f;
      `IO_SP_LO_ADDR: return s[7:0];
      `IO_SP_HI_ADDR: return s[15:8];
      default:        return 8'h00;
    endcase
  endfunction

  assign ds_reg_hit = in_regs(DS_ADDR);
  assign ds_io_hit  = in_io(DS_ADDR);
  assign io_wr      = IO_WE | (DS_WE & ds_io_hit);
  assign io_wa      = IO_WE ? IO_ADDR : 6'(DS_ADDR - `DS_IO_BASE);
  assign io_wd      = IO_WE ? IO_WDATA : DS_WDATA;
  assign io_rd      = IO_RE | (DS_RE & ds_io_hit);
  assign io_ra      = IO_RE ? IO_ADDR : 6'(DS_ADDR - `DS_IO_BASE);
  assign hi_idx_a   = RD_IDX_A + 5'h01;

  // third read port: high half of word operand, else data space or copy
  always_comb begin
    if (SCHEME == SCH_ONE16) begin
      idx_c = hi_idx_a;
    end else if (DS_RE && ds_reg_hit) begin
      idx_c = DS_ADDR[4:0];
    end else begin
      idx_c = COPY_IDX;
    end
  end

  // memory write arbitration: alu result, then data space, then bit load
  always_comb begin
    mem_we_lo = 1'b0;
    mem_we_hi = 1'b0;
    mem_widx  = RES_IDX;
    mem_wlo   = RES_DATA[7:0];
    mem_whi   = RES_DATA[15:8];
    if (RES_WE) begin
      mem_we_lo = 1'b1;
      mem_we_hi = (SCHEME == SCH_TWO16) || (SCHEME == SCH_ONE16);
    end else if (DS_WE && ds_reg_hit) begin
      mem_we_lo = 1'b1;
      mem_widx  = DS_ADDR[4:0];
      mem_wlo   = DS_WDATA;
    end else if (COPY_TO) begin
      mem_we_lo = 1'b1;
      mem_widx  = COPY_IDX;
      mem_wlo   = copy_src_q;
      mem_wlo[COPY_BIT] = flags_q[`FLG_COPY];
    end
  end

  // storage; reads forward same-cycle writes
  regfile_mem #(.NREGS(`RF_NUM_REGS)) u_mem (
    .clk      (CLK),
    .rst      (SYS_RST),
    .we_lo    (mem_we_lo),
    .we_hi    (mem_we_hi),
    .wr_idx   (mem_widx),
    .wr_lo    (mem_wlo),
    .wr_hi    (mem_whi),
    .rd_idx_a (RD_IDX_A),
    .rd_idx_b (RD_IDX_B),
    .rd_idx_c (idx_c),
    .rd_a     (rd_a),
    .rd_b     (rd_b),
    .rd_c     (rd_c)
  );

  // operand outputs follow the port scheme
  always_comb begin
    case (SCHEME)
      SCH_ONE16: OPND_A = {rd_c, rd_a};
      default:   OPND_A = {8'h00, rd_a};
    endcase
    OPND_B   = rd_b;
    DS_RDATA = ds_reg_hit ? rd_c : IO_RDATA;
  end

  // register copy of the bit-load source, tracks the selected register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      copy_src_q <= 8'h00;
    end else if (mem_we_lo && mem_widx == COPY_IDX) begin
      copy_src_q <= mem_wlo;
    end else begin
      copy_src_q <= rd_c;
    end
  end

  // next flag word
  always_comb begin
    flags_d = flags_q;
    if (FLAG_WE) begin
      flags_d = (flags_q & ~FLAG_UPD.mask) | (FLAG_UPD.value & FLAG_UPD.mask);
    end
    if (COPY_FROM) begin
      flags_d[`FLG_COPY] = copy_src_q[COPY_BIT];
    end
    if (io_wr && io_wa == `IO_FLAGS_ADDR) begin
      flags_d = io_wd;
    end
    if (GATE_ON || IRQ_RET) begin
      flags_d[`FLG_GATE] = 1'b1;
    end
    if (GATE_OFF || IRQ_TAKE) begin
      flags_d[`FLG_GATE] = 1'b0;
    end
    flags_d[`FLG_POLARITY] = flags_d[`FLG_MSB] ^ flags_d[`FLG_SWRAP];
  end

  // flag word register; nothing saved on interrupt entry
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      flags_q <= `FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // gate tracking state
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      irq_q <= IRQ_IDLE;
    end else begin
      case (irq_q)
        IRQ_IDLE:   irq_q <= IRQ_TAKE ? IRQ_TAKEN : IRQ_IDLE;
        IRQ_TAKEN:  irq_q <= IRQ_RET ? IRQ_RETURN : IRQ_TAKEN;
        IRQ_RETURN: irq_q <= IRQ_IDLE;
        default:    irq_q <= IRQ_IDLE;
      endcase
    end
  end

  // grant and priority; gate-off blocks even in the same cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      IRQ_GRANT <= 1'b0;
      IRQ_VEC   <= 3'h0;
    end else begin
      IRQ_GRANT <= flags_d[`FLG_GATE] && (|IRQ_PEND)
                   && (irq_q != IRQ_RETURN);
      IRQ_VEC   <= 3'h0;
      for (int i = 7; i >= 0; i--) begin
        if (IRQ_PEND[i]) begin
          IRQ_VEC <= 3'(i);
        end
      end
    end
  end

  // stack pointer: io writable, moves by two on call and return
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sp_q <= `SP_RESET;
    end else if (io_wr && io_wa == `IO_SP_LO_ADDR) begin
      sp_q[7:0] <= io_wd;
    end else if (io_wr && io_wa == `IO_SP_HI_ADDR) begin
      sp_q[15:8] <= io_wd;
    end else if (SP_PUSH2) begin
      sp_q <= sp_q - 16'h0002;
    end else if (SP_POP2) begin
      sp_q <= sp_q + 16'h0002;
    end
  end

  // pointer mirrors, updated from register writes to pairs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      x_q <= 16'h0000;
      y_q <= 16'h0000;
      z_q <= 16'h0000;
    end else begin
      for (int r = 0; r < 2; r++) begin
        if ((r == 0 && mem_we_lo) || (r == 1 && mem_we_hi)) begin
          case (5'(mem_widx + 5'(r)))
            5'h1a: x_q[7:0]  <= r == 0 ? mem_wlo : mem_whi;
            5'h1b: x_q[15:8] <= r == 0 ? mem_wlo : mem_whi;
            5'h1c: y_q[7:0]  <= r == 0 ? mem_wlo : mem_whi;
            5'h1d: y_q[15:8] <= r == 0 ? mem_wlo : mem_whi;
            5'h1e: z_q[7:0]  <= r == 0 ? mem_wlo : mem_whi;
            5'h1f: z_q[15:8] <= r == 0 ? mem_wlo : mem_whi;
            default: ;
          endcase
        end
      end
    end
  end

  // registered pointer and status outputs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PTR_X     <= 16'h0000;
      PTR_Y     <= 16'h0000;
      PTR_Z     <= 16'h0000;
      FLAGS     <= `FLAGS_RESET;
      SP_OUT    <= `SP_RESET;
    end else begin
      PTR_X     <= x_q;
      PTR_Y     <= y_q;
      PTR_Z     <= z_q;
      FLAGS     <= flags_q;
      SP_OUT    <= sp_q;
    end
  end

  // io read data and window indication
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      IO_RDATA  <= 8'h00;
      DS_IO_HIT <= 1'b0;
      IO_SEL    <= 6'h00;
    end else begin
      IO_RDATA  <= io_rd ? io_mux(io_ra, flags_d, sp_q) : 8'h00;
      DS_IO_HIT <= DS_RE & ds_io_hit;
      IO_SEL    <= io_wr ? io_wa : io_ra;
    end
  end

  // prefetch: next word latched while current executes
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      insn_q <= 16'h0000;
      long_q <= 1'b0;
    end else if (PM_VALID) begin
      insn_q <= PM_WORD;
      long_q <= (PM_WORD[15:10] == 6'h24) && (PM_WORD[3:1] != 3'h0);
    end
  end

  assign INSN_Q    = insn_q;
  assign INSN_LONG = long_q;
endmodule

// *** test/cpu_ctl_model.sv ***
// decoder and alu side model issuing register file requests
`timescale 1ns/1ps
module cpu_ctl_model
  import cpu_regfile_pkg::*;
(
  input  wire logic   CLK,       // cpu clock
  output ridx_t       RD_IDX_A,  // operand a
  output ridx_t       RD_IDX_B,  // operand b
  output scheme_e     SCHEME,    // width scheme
  output logic        RES_WE,    // result write
  output ridx_t       RES_IDX,   // result reg
  output logic [15:0] RES_DATA,  // result data
  output logic        FLAG_WE,   // flag strobe
  output flag_upd_s   FLAG_UPD,  // flag bundle
  output logic        COPY_FROM, // bit to flag
  output logic        COPY_TO,   // flag to bit
  output logic [2:0]  COPY_BIT,  // bit select
  output ridx_t       COPY_IDX,  // reg select
  output logic        GATE_ON,   // gate set op
  output logic        GATE_OFF,  // gate clear op
  output logic        IRQ_TAKE,  // irq entry
  output logic        IRQ_RET,   // irq return
  output byte_t       IRQ_PEND,  // pending lines
  output logic        DS_RE,     // data read
  output logic        DS_WE,     // data write
  output logic [15:0] DS_ADDR,   // data address
  output byte_t       DS_WDATA,  // data wdata
  output logic        IO_RE,     // io read
  output logic        IO_WE,     // io write
  output logic [5:0]  IO_ADDR,   // io address
  output byte_t       IO_WDATA,  // io wdata
  output logic        SP_PUSH2,  // push two
  output logic        SP_POP2,   // pop two
  output logic [15:0] PM_WORD,   // fetch word
  output logic        PM_VALID   // fetch valid
);
  // release every strobe, qualifiers stay
  task automatic drop();
    {RES_WE, FLAG_WE, COPY_FROM, COPY_TO, GATE_ON, GATE_OFF, IRQ_TAKE, IRQ_RET} = 8'h00;
    {DS_RE, DS_WE, IO_RE, IO_WE, SP_PUSH2, SP_POP2, PM_VALID} = 7'h00;
  endtask
  // let the sampling edge pass, then release
  task automatic tick();
    @(posedge CLK);
    #1;
    drop();
  endtask
  // idle values at time zero
  initial begin
    drop();
    {RD_IDX_A, RD_IDX_B, RES_IDX, COPY_IDX, COPY_BIT} = 23'h000000;
    {RES_DATA, DS_ADDR, PM_WORD} = 48'h000000000000;
    {DS_WDATA, IO_WDATA, IRQ_PEND, IO_ADDR} = 30'h00000000;
    SCHEME = SCH_ONE8;
    FLAG_UPD = 16'h0000;
  end
  // result write, operand a index alongside
  task automatic res_wr(input ridx_t idx, input logic [15:0] d, input scheme_e s,
                        input ridx_t rda);
    RES_WE = 1'b1;
    RES_IDX = idx;
    RES_DATA = d;
    SCHEME = s;
    RD_IDX_A = rda;
    tick();
  endtask
  // operand selection only
  task automatic read(input ridx_t a, input ridx_t b, input scheme_e s);
    RD_IDX_A = a;
    RD_IDX_B = b;
    SCHEME = s;
    tick();
  endtask
  // masked flag update from the alu
  task automatic flags(input byte_t m, input byte_t v);
    FLAG_WE = 1'b1;
    FLAG_UPD = {m, v};
    tick();
  endtask
  // one-hot: gate on, gate off, take, return, push, pop
  task automatic pulse(input logic [5:0] sel);
    GATE_ON  = sel[5];
    GATE_OFF = sel[4];
    IRQ_TAKE = sel[3];
    IRQ_RET  = sel[2];
    SP_PUSH2 = sel[1];
    SP_POP2  = sel[0];
    tick();
  endtask
  // pending interrupt lines, level
  task automatic pend(input byte_t v);
    IRQ_PEND = v;
  endtask
  // data space access
  task automatic ds(input logic we, input logic [15:0] a, input byte_t d);
    DS_WE = we;
    DS_RE = !we;
    DS_ADDR = a;
    DS_WDATA = d;
    tick();
  endtask
  // direct io access
  task automatic io(input logic we, input logic [5:0] a, input byte_t d);
    IO_WE = we;
    IO_RE = !we;
    IO_ADDR = a;
    IO_WDATA = d;
    tick();
  endtask
  // bit copy, register selected two cycles ahead for the source copy
  task automatic copy(input logic to, input ridx_t idx, input logic [2:0] b);
    COPY_IDX = idx;
    COPY_BIT = b;
    tick();
    tick();
    COPY_FROM = !to;
    COPY_TO = to;
    tick();
  endtask
  // hand one program word to the prefetch
  task automatic fetch(input logic [15:0] w);
    PM_WORD = w;
    PM_VALID = 1'b1;
    tick();
  endtask
endmodule

// *** test/regfile_monitor.sv ***
// timing checker for the register file and flag word
`timescale 1ns/1ps
module regfile_monitor
  import cpu_regfile_pkg::*;
(
  input wire logic        CLK,       // cpu clock
  input wire logic        SYS_RST,   // sync reset
  input wire scheme_e     SCHEME,    // width scheme
  input wire logic        RES_WE,    // result write
  input wire logic [4:0]  RES_IDX,   // result reg
  input wire logic [15:0] RES_DATA,  // result data
  input wire logic [4:0]  RD_IDX_A,  // operand a
  input wire logic        FLAG_WE,   // flag strobe
  input wire flag_upd_s   FLAG_UPD,  // flag bundle
  input wire logic        COPY_FROM, // bit to flag
  input wire logic        COPY_TO,   // flag to bit
  input wire logic        GATE_ON,   // gate set
  input wire logic        GATE_OFF,  // gate clear
  input wire logic        IRQ_TAKE,  // irq entry
  input wire logic        IRQ_RET,   // irq return
  input wire logic [7:0]  IRQ_PEND,  // pending lines
  input wire logic        DS_WE,     // data write
  input wire logic        IO_WE,     // io write
  input wire logic [15:0] OPND_A,    // operand a out
  input wire logic [7:0]  FLAGS,     // flag word
  input wire logic [15:0] PTR_X,     // pointer x
  input wire logic [15:0] SP_OUT,    // stack pointer
  input wire logic        IRQ_GRANT, // grant
  input wire logic [2:0]  IRQ_VEC    // winning vector
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // no source may touch the flag word this cycle
  wire quiet = !(FLAG_WE || GATE_ON || GATE_OFF || IRQ_TAKE || IRQ_RET || COPY_FROM ||
                 IO_WE || DS_WE);
  // lowest pending line number
  function automatic logic [2:0] low_idx(input logic [7:0] p);
    low_idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (p[i]) begin
        low_idx = 3'(i);
      end
    end
  endfunction
  a_reset_zero: assert property ($fell(SYS_RST) |-> FLAGS == 8'h00 && SP_OUT == 16'h0000)
    else $error("state not clear after reset");
  a_sign_xor: assert property (FLAGS[4] == (FLAGS[2] ^ FLAGS[3]))
    else $error("sign bit not n xor v");
  a_flag_update: assert property (FLAG_WE ##1 quiet |-> ##1
    ((FLAGS ^ $past(FLAG_UPD.value, 2)) & $past(FLAG_UPD.mask, 2) & 8'hef) == 8'h00)
    else $error("masked flag update lost");
  a_gate_clear: assert property ((IRQ_TAKE || GATE_OFF) ##1 quiet |-> ##1 !FLAGS[7])
    else $error("gate not cleared");
  a_gate_set: assert property (((GATE_ON || IRQ_RET) && !IRQ_TAKE && !GATE_OFF) ##1 quiet
    |-> ##1 FLAGS[7])
    else $error("gate not set");
  a_gate_blocks: assert property (IRQ_GRANT |-> ##1 FLAGS[7])
    else $error("grant while gate clear");
  a_irq_prio: assert property (IRQ_GRANT && $past(IRQ_PEND) == $past(IRQ_PEND, 2) &&
    $past(IRQ_PEND, 2) == $past(IRQ_PEND, 3) |-> IRQ_VEC == low_idx($past(IRQ_PEND)))
    else $error("vector not lowest pending");
  a_fwd_read: assert property (RES_WE && SCHEME == SCH_ONE8 && RD_IDX_A == RES_IDX
    |=> OPND_A[7:0] == $past(RES_DATA[7:0]))
    else $error("write not forwarded to read");
  a_pair_ptr: assert property ((RES_WE && RES_IDX == 5'h1a && SCHEME == SCH_TWO16) ##1
    (!DS_WE && !COPY_TO && !(RES_WE && RES_IDX[4:1] == 4'hd)) |-> ##1 PTR_X == $past(RES_DATA, 2))
    else $error("pointer pair mismatch");
  c_flag_write: cover property (FLAG_WE);
  c_grant: cover property (IRQ_GRANT);
  c_copy_to: cover property (COPY_TO);
  c_wide_write: cover property (RES_WE && SCHEME == SCH_TWO16);
endmodule
bind cpu_regfile regfile_monitor i_regfile_monitor (
  .CLK, .SYS_RST, .SCHEME, .RES_WE, .RES_IDX, .RES_DATA, .RD_IDX_A, .FLAG_WE, .FLAG_UPD,
  .COPY_FROM, .COPY_TO, .GATE_ON, .GATE_OFF, .IRQ_TAKE, .IRQ_RET, .IRQ_PEND, .DS_WE, .IO_WE,
  .OPND_A, .FLAGS, .PTR_X, .SP_OUT, .IRQ_GRANT, .IRQ_VEC
);

// *** test/testbench.sv ***
// self-checking bench for the register file and flag word
`timescale 1ns/1ps
module testbench
  import cpu_regfile_pkg::*;
;
  logic             CLK, SYS_RST;                       // clock and reset
  wire  [4:0]       RD_IDX_A, RD_IDX_B, RES_IDX, COPY_IDX; // indices
  wire  scheme_e    SCHEME;                             // width scheme
  wire  flag_upd_s  FLAG_UPD;                           // flag bundle
  wire  [15:0]      RES_DATA, DS_ADDR, PM_WORD;         // wide inputs
  wire  [7:0]       IRQ_PEND, DS_WDATA, IO_WDATA;       // byte inputs
  wire  [5:0]       IO_ADDR, IO_SEL;                    // io addresses
  wire  [2:0]       COPY_BIT;                           // bit select
  wire              RES_WE, FLAG_WE, COPY_FROM, COPY_TO, GATE_ON, GATE_OFF, IRQ_TAKE, IRQ_RET;
  wire              DS_RE, DS_WE, IO_RE, IO_WE, SP_PUSH2, SP_POP2, PM_VALID;
  wire  [15:0]      OPND_A, PTR_X, PTR_Y, PTR_Z, SP_OUT, INSN_Q; // wide outputs
  wire  [7:0]       OPND_B, FLAGS, DS_RDATA, IO_RDATA;  // byte outputs
  wire  [2:0]       IRQ_VEC;                            // vector
  wire              DS_IO_HIT, IRQ_GRANT, INSN_LONG;    // status
  int               error_cnt = 0;                      // mismatches
  int               cmp_count = 0;                      // comparisons
  int               fb[5] = '{0, 1, 2, 3, 5};           // flag bits walked
  cpu_ctl_model i_cpu_ctl_model (
    .CLK, .RD_IDX_A, .RD_IDX_B, .SCHEME, .RES_WE, .RES_IDX, .RES_DATA, .FLAG_WE, .FLAG_UPD,
    .COPY_FROM, .COPY_TO, .COPY_BIT, .COPY_IDX, .GATE_ON, .GATE_OFF, .IRQ_TAKE, .IRQ_RET,
    .IRQ_PEND, .DS_RE, .DS_WE, .DS_ADDR, .DS_WDATA, .IO_RE, .IO_WE, .IO_ADDR, .IO_WDATA,
    .SP_PUSH2, .SP_POP2, .PM_WORD, .PM_VALID
  );
  cpu_regfile i_cpu_regfile (
    .CLK, .SYS_RST, .RD_IDX_A, .RD_IDX_B, .SCHEME, .RES_WE, .RES_IDX, .RES_DATA, .FLAG_WE,
    .FLAG_UPD, .COPY_FROM, .COPY_TO, .COPY_BIT, .COPY_IDX, .GATE_ON, .GATE_OFF, .IRQ_TAKE,
    .IRQ_RET, .IRQ_PEND, .DS_RE, .DS_WE, .DS_ADDR, .DS_WDATA, .IO_RE, .IO_WE, .IO_ADDR,
    .IO_WDATA, .SP_PUSH2, .SP_POP2, .PM_WORD, .PM_VALID, .OPND_A, .OPND_B, .FLAGS, .PTR_X,
    .PTR_Y, .PTR_Z, .DS_RDATA, .DS_IO_HIT, .IO_SEL, .IO_RDATA, .IRQ_GRANT, .IRQ_VEC,
    .SP_OUT, .INSN_Q, .INSN_LONG
  );
  // 100 ns clock
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // let registered outputs settle
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // verdict and end of run
  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // hang guard, far beyond the roughly seventy cycles used
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end
  // main sequence
  initial begin
    SYS_RST = 1'b1;
    repeat (2) @(posedge CLK);
    #1;
    SYS_RST = 1'b0;
    chk(16'(FLAGS), 16'h0000);
    i_cpu_ctl_model.res_wr(5'h03, 16'h0055, SCH_ONE8, 5'h03);
    chk(OPND_A, 16'h0055);
    i_cpu_ctl_model.res_wr(5'h01, 16'h00a1, SCH_ONE8, 5'h03);
    i_cpu_ctl_model.res_wr(5'h02, 16'h00b2, SCH_ONE8, 5'h03);
    i_cpu_ctl_model.read(5'h01, 5'h02, SCH_TWO8);
    chk(16'(OPND_A[7:0]), 16'h00a1);
    chk(16'(OPND_B), 16'h00b2);
    // pointer pairs written back to back as words
    for (int k = 0; k < 3; k++) begin
      i_cpu_ctl_model.res_wr(5'h1a + 5'(2 * k), 16'h1234 + 16'(k), SCH_TWO16, 5'h00);
    end
    wt(2);
    chk(PTR_X, 16'h1234);
    chk(PTR_Y, 16'h1235);
    chk(PTR_Z, 16'h1236);
    i_cpu_ctl_model.read(5'h1e, 5'h1b, SCH_ONE16);
    chk(OPND_A, 16'h1236);
    chk(16'(OPND_B), 16'h0012);
    i_cpu_ctl_model.ds(1'b1, 16'h0005, 8'ha5);
    i_cpu_ctl_model.read(5'h05, 5'h1a, SCH_ONE8);
    chk(16'(OPND_A[7:0]), 16'h00a5);
    i_cpu_ctl_model.ds(1'b0, 16'h001c, 8'h00);
    chk(16'(DS_RDATA), 16'h0035);
    // each arithmetic flag alone, sign follows n xor v
    foreach (fb[i]) begin
      i_cpu_ctl_model.flags(8'h3f, 8'h01 << fb[i]);
      wt(2);
      chk(16'(FLAGS), (16'h0001 << fb[i]) | ((fb[i] == 2 || fb[i] == 3) ? 16'h0010 : 16'h0000));
    end
    // gate, entry, return, priority
    i_cpu_ctl_model.flags(8'h3f, 8'h21);
    i_cpu_ctl_model.pend(8'h0c);
    i_cpu_ctl_model.pulse(6'h20);
    wt(3);
    chk(16'(FLAGS), 16'h00a1);
    chk(16'(IRQ_GRANT), 16'h0001);
    chk(16'(IRQ_VEC), 16'h0002);
    i_cpu_ctl_model.pulse(6'h08);
    wt(2);
    chk(16'(FLAGS), 16'h0021);
    chk(16'(IRQ_GRANT), 16'h0000);
    i_cpu_ctl_model.pulse(6'h04);
    wt(2);
    chk(16'(FLAGS), 16'h00a1);
    i_cpu_ctl_model.pulse(6'h10);
    wt(2);
    chk(16'(FLAGS), 16'h0021);
    chk(16'(IRQ_GRANT), 16'h0000);
    // bit copy out of r7 and into r9
    i_cpu_ctl_model.res_wr(5'h07, 16'h0008, SCH_ONE8, 5'h00);
    i_cpu_ctl_model.copy(1'b0, 5'h07, 3'h3);
    wt(2);
    chk(16'(FLAGS), 16'h0061);
    i_cpu_ctl_model.copy(1'b1, 5'h09, 3'h0);
    i_cpu_ctl_model.read(5'h09, 5'h00, SCH_ONE8);
    chk(16'(OPND_A[7:0]), 16'h0001);
    // io window in data space and direct io
    i_cpu_ctl_model.ds(1'b1, 16'h005f, 8'h41);
    wt(2);
    chk(16'(FLAGS), 16'h0041);
    i_cpu_ctl_model.io(1'b0, 6'h3f, 8'h00);
    chk(16'(IO_RDATA), 16'h0041);
    i_cpu_ctl_model.ds(1'b0, 16'h005f, 8'h00);
    chk(16'(DS_IO_HIT), 16'h0001);
    chk(16'(DS_RDATA), 16'h0041);
    chk(16'(IO_SEL), 16'h003f);
    i_cpu_ctl_model.io(1'b0, 6'h10, 8'h00);
    chk(16'(IO_RDATA), 16'h0000);
    // stack pointer via io, two-byte push and pop
    i_cpu_ctl_model.io(1'b1, 6'h3d, 8'h80);
    i_cpu_ctl_model.io(1'b1, 6'h3e, 8'h08);
    wt(2);
    chk(SP_OUT, 16'h0880);
    i_cpu_ctl_model.pulse(6'h02);
    wt(2);
    chk(SP_OUT, 16'h087e);
    i_cpu_ctl_model.pulse(6'h01);
    wt(2);
    chk(SP_OUT, 16'h0880);
    i_cpu_ctl_model.fetch(16'h2c01);
    chk(INSN_Q, 16'h2c01);
    chk(16'(INSN_LONG), 16'h0000);
    finish_test();
  end
endmodule
